// File: verilog/hbl_host.sv
// host end: drives register accesses and serial lines on the pins
`timescale 1ns/1ps
module hbl_host (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  // pins
  hbl_if.host                              pins,
  // configuration, held steady while busy
  input  wire logic                        cfg_wide,
  input  wire logic                        cfg_swap,
  input  wire logic                        cfg_serial,
  input  wire logic                        cfg_muxed,
  // command side
  input  wire logic                        cmd_valid,
  output logic                             cmd_ready,
  input  wire logic                        cmd_write,
  input  wire logic [hbl_pkg::IDX_W-1:0]   cmd_index,
  input  wire logic [hbl_pkg::DATA_W-1:0]  cmd_wdata,
  output logic                             rsp_valid,
  output logic [hbl_pkg::DATA_W-1:0]       rsp_rdata,
  // serial side
  input  wire logic                        ser_cs,
  input  wire logic                        ser_mosi,
  output logic                             ser_miso
);
  // ---------------------------------------------------------------
  // data pin synchroniser
  // ---------------------------------------------------------------
  logic [hbl_pkg::DATA_W-1:0]   s1_ff;
  logic [hbl_pkg::DATA_W-1:0]   s2_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= hbl_pkg::ZERO16;
      s2_ff <= hbl_pkg::ZERO16;
    end else begin
      s1_ff <= pins.d;
      s2_ff <= s1_ff;
    end
  end
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  hbl_pkg::hbl_hst_e            st_ff;
  hbl_pkg::hbl_hst_e            nxt_st;
  logic [hbl_pkg::CNT_W-1:0]    cnt_ff;      // cycles left in phase
  logic [hbl_pkg::CNT_W-1:0]    nxt_cnt;
  logic                         byte_ff;     // narrow: 0 low, 1 high
  logic                         wr_ff;       // latched direction
  logic [hbl_pkg::IDX_W-1:0]    idx_ff;
  logic [hbl_pkg::DATA_W-1:0]   wd_ff;
  logic [hbl_pkg::DATA_W-1:0]   rd_ff;
  logic                         rsp_ff;
  localparam logic [hbl_pkg::CNT_W-1:0] PH_C =
    hbl_pkg::CNT_W'(hbl_pkg::PHASE_CYC - 1);
  localparam logic [hbl_pkg::CNT_W-1:0] ST_C =
    hbl_pkg::CNT_W'(hbl_pkg::STROBE_CYC - 1);
  wire cnt_done = (cnt_ff == {hbl_pkg::CNT_W{1'b0}});
  wire take     = cmd_valid & cmd_ready;
  wire more     = ~cfg_wide & ~byte_ff;      // second byte pending
  assign cmd_ready = (st_ff == hbl_pkg::HBL_IDLE) & ~cfg_serial;
  // phase order: address, latch, strobe, hold, then next byte
  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 1'b1;
    case (st_ff)
      hbl_pkg::HBL_IDLE: begin
        nxt_cnt = PH_C;
        if (take) nxt_st = hbl_pkg::HBL_ADDR;
      end
      hbl_pkg::HBL_ADDR: begin
        if (cnt_done) begin
          nxt_st  = hbl_pkg::HBL_LATCH;
          nxt_cnt = PH_C;
        end
      end
      hbl_pkg::HBL_LATCH: begin
        if (cnt_done) begin
          nxt_st  = hbl_pkg::HBL_STRB;
          nxt_cnt = ST_C;
        end
      end
      hbl_pkg::HBL_STRB: begin
        if (cnt_done) begin
          nxt_st  = hbl_pkg::HBL_HOLD;
          nxt_cnt = PH_C;
        end
      end
      hbl_pkg::HBL_HOLD: begin
        if (cnt_done) begin
          nxt_st  = more ? hbl_pkg::HBL_ADDR : hbl_pkg::HBL_IDLE;
          nxt_cnt = PH_C;
        end
      end
      default: begin
        nxt_st  = hbl_pkg::HBL_IDLE;
        nxt_cnt = PH_C;
      end
    endcase
  end
  // read byte taken on the last strobe cycle from the synced pins
  wire samp = (st_ff == hbl_pkg::HBL_STRB) & cnt_done & ~wr_ff;
  wire [hbl_pkg::DATA_W-1:0] rd_wide =
    cfg_swap ? {s2_ff[7:0], s2_ff[15:8]} : s2_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff   <= hbl_pkg::HBL_IDLE;
      cnt_ff  <= {hbl_pkg::CNT_W{1'b0}};
      byte_ff <= 1'b0;
      wr_ff   <= 1'b0;
      idx_ff  <= hbl_pkg::ZERO8;
      wd_ff   <= hbl_pkg::ZERO16;
      rd_ff   <= hbl_pkg::ZERO16;
      rsp_ff  <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
      rsp_ff <= (st_ff == hbl_pkg::HBL_HOLD) & cnt_done & ~more;
      if (take) begin
        byte_ff <= 1'b0;
        wr_ff   <= cmd_write;
        idx_ff  <= cmd_index;
        wd_ff   <= cmd_wdata;
      end else if (st_ff == hbl_pkg::HBL_HOLD && cnt_done) begin
        byte_ff <= ~byte_ff;
      end
      if (samp) begin
        if (cfg_wide) rd_ff <= rd_wide;
        else if (byte_ff) rd_ff[15:8] <= s2_ff[7:0];
        else rd_ff[7:0] <= s2_ff[7:0];
      end
    end
  end
  assign rsp_valid = rsp_ff;
  assign rsp_rdata = rd_ff;
  // ---------------------------------------------------------------
  // pin drivers, registered
  // ---------------------------------------------------------------
  wire busy   = (st_ff != hbl_pkg::HBL_IDLE);
  wire in_adr = (st_ff == hbl_pkg::HBL_ADDR);
  wire in_stb = (st_ff == hbl_pkg::HBL_STRB);
  wire wr_dat = wr_ff & (in_stb | (st_ff == hbl_pkg::HBL_HOLD));
  // the swap strap must not follow the byte counter in wide width
  wire a0     = cfg_wide ? cfg_swap : byte_ff;
  // muxed hosts clear the index bits once latched, proving the latch; bit 0 stays driven
  wire show_a = in_adr | ~cfg_muxed;
  wire [hbl_pkg::ADDR_W-1:0] nxt_addr =
    {2'b00, (show_a ? idx_ff : hbl_pkg::ZERO8), a0};
  wire [hbl_pkg::BYTE_W-1:0] wbyte = byte_ff ? wd_ff[15:8] : wd_ff[7:0];
  wire [hbl_pkg::DATA_W-1:0] wword =
    cfg_swap ? {wd_ff[7:0], wd_ff[15:8]} : wd_ff;
  wire [hbl_pkg::DATA_W-1:0] ser_oe =
    {{(hbl_pkg::DATA_W-1){1'b0}}, 1'b1} << hbl_pkg::SER_IN_BIT;
  wire [hbl_pkg::DATA_W-1:0] nxt_doe =
    cfg_serial ? ser_oe :
    !wr_dat    ? hbl_pkg::ZERO16 :
    cfg_wide   ? {hbl_pkg::ONES8, hbl_pkg::ONES8} :
                 {hbl_pkg::ZERO8, hbl_pkg::ONES8};
  wire [hbl_pkg::DATA_W-1:0] nxt_dout =
    cfg_serial ? (ser_mosi ? ser_oe : hbl_pkg::ZERO16) :
    cfg_wide   ? wword : {hbl_pkg::ZERO8, wbyte};
  // ale low after the address phase only for multiplexed hosts
  wire nxt_ale = ~cfg_muxed | in_adr | ~busy;
  wire nxt_csn = cfg_serial ? ~ser_cs : ~busy;
  logic [5:0]                   ctl_ff;      // cs_n,ale,rd_n,wr_n,w,s
  logic [hbl_pkg::ADDR_W-1:0]   addr_ff;
  logic [hbl_pkg::DATA_W-1:0]   dout_ff;
  logic [hbl_pkg::DATA_W-1:0]   doe_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_ff  <= hbl_pkg::CTL_RST;
      addr_ff <= {hbl_pkg::ADDR_W{1'b0}};
      dout_ff <= hbl_pkg::ZERO16;
      doe_ff  <= hbl_pkg::ZERO16;
    end else begin
      ctl_ff  <= {nxt_csn, nxt_ale, ~(in_stb & ~wr_ff),
                  ~(in_stb & wr_ff), cfg_wide, cfg_serial};
      addr_ff <= nxt_addr;
      dout_ff <= nxt_dout;
      doe_ff  <= nxt_doe;
    end
  end
  assign pins.cs_n   = ctl_ff[5];
  assign pins.ale    = ctl_ff[4];
  assign pins.rd_n   = ctl_ff[3];
  assign pins.wr_n   = ctl_ff[2];
  assign pins.wide   = ctl_ff[1];
  assign pins.serial = ctl_ff[0];
  assign pins.addr   = addr_ff;
  assign pins.h_d_o  = dout_ff;
  assign pins.h_d_oe = doe_ff;
  assign ser_miso    = s2_ff[hbl_pkg::SER_OUT_BIT];
endmodule

// File: verilog/hbl_pkg.sv
// shared constants and types for the host bus lane and pin share block
package hbl_pkg;
  // ---------------------------------------------------------------
  // pin widths
  // ---------------------------------------------------------------
  localparam int ADDR_W     = 11;            // address pins 10:0
  localparam int DATA_W     = 16;            // data pins 15:0
  localparam int IDX_W      = 8;             // register index, addr 8:1
  localparam int IDX_LSB    = 1;             // lowest index bit on pins
  localparam int BYTE_W     = 8;             // one byte lane
  localparam int SER_IN_BIT = 1;             // serial data from host
  localparam int SER_OUT_BIT = 0;            // serial data to host
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;         // 100 MHz system clock
  localparam int STROBE_NS     = 80;         // least strobe low time
  localparam int PHASE_NS      = 30;         // least setup / hold time
  localparam int STROBE_CYC    =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_CYC     =
    (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;          // phase counter width
  // ---------------------------------------------------------------
  // reset values of pin-facing flops
  // ---------------------------------------------------------------
  localparam logic [5:0] CTL_RST = 6'h3D;    // cs_n,ale,rd_n,wr_n,s hi
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0]  ZERO8  = 8'h00;
  localparam logic [7:0]  ONES8  = 8'hFF;
  // ---------------------------------------------------------------
  // host sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    HBL_IDLE  = 5'h01,                       // waiting for a command
    HBL_ADDR  = 5'h02,                       // address out, latch open
    HBL_LATCH = 5'h04,                       // latch strobe dropped
    HBL_STRB  = 5'h08,                       // read or write strobe low
    HBL_HOLD  = 5'h10                        // strobe high, data held
  } hbl_hst_e;
endpackage

// File: verilog/hbl_if.sv
// pin bundle between the host end and the device end
`timescale 1ns/1ps
interface hbl_if;
  // host driven pins
  logic                       cs_n;      // device select, low active
  logic                       ale;       // address latch strobe
  logic                       rd_n;      // read strobe, low active
  logic                       wr_n;      // write strobe, low active
  logic                       wide;      // width select, 1 = 16 bit
  logic                       serial;    // serial host mode select
  logic [hbl_pkg::ADDR_W-1:0] addr;      // address pins, bit 0 shared
  // data pins, two drivers each
  logic [hbl_pkg::DATA_W-1:0] h_d_o;     // host data out
  logic [hbl_pkg::DATA_W-1:0] h_d_oe;    // host drives the bit
  logic [hbl_pkg::DATA_W-1:0] d_d_o;     // device data out
  logic [hbl_pkg::DATA_W-1:0] d_d_oe;    // device drives the bit
  logic [hbl_pkg::DATA_W-1:0] d;         // resolved pin level
  // resolved level: an undriven pin floats high as if pulled up
  assign d = (h_d_oe & h_d_o) | (d_d_oe & d_d_o) | ~(h_d_oe | d_d_oe);
  modport host (output cs_n, ale, rd_n, wr_n, wide, serial, addr,
                output h_d_o, h_d_oe, input d);
  modport dev  (input cs_n, ale, rd_n, wr_n, wide, serial, addr,
                output d_d_o, d_d_oe, input d);
endinterface

// File: verilog/hbl_dev.sv
// device end: pin sharing, address latch and byte lane steering
`timescale 1ns/1ps
module hbl_dev (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  // pins
  hbl_if.dev                               pins,
  // register side
  output logic [hbl_pkg::IDX_W-1:0]        reg_index,
  output logic                             reg_byte_hi,
  input  wire logic [hbl_pkg::DATA_W-1:0]  reg_rdata,
  output logic                             reg_rd,
  output logic                             reg_wr,
  output logic [hbl_pkg::DATA_W-1:0]       reg_wdata,
  output logic [1:0]                       reg_wbe,
  // serial side
  output logic                             ser_sdi,
  input  wire logic                        ser_sdo,
  output logic                             ser_cs
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int SW = 6 + hbl_pkg::ADDR_W + hbl_pkg::DATA_W;
  localparam logic [SW-1:0] SYNC_RST =
    {hbl_pkg::CTL_RST, {hbl_pkg::ADDR_W{1'b0}}, hbl_pkg::ZERO16};
  logic [SW-1:0]                s1_ff;       // first stage, raw pins
  logic [SW-1:0]                s2_ff;       // second stage, usable
  wire  [SW-1:0]                pin_vec =
    {pins.cs_n, pins.ale, pins.rd_n, pins.wr_n, pins.wide,
     pins.serial, pins.addr, pins.d};
  // every pin is asynchronous to clk, so all pass two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
    end else begin
      s1_ff <= pin_vec;
      s2_ff <= s1_ff;
    end
  end
  // named views of the second stage
  wire                          cs_s   = ~s2_ff[SW-1];
  wire                          ale_s  = s2_ff[SW-2];
  wire                          rd_s   = ~s2_ff[SW-3];
  wire                          wr_s   = ~s2_ff[SW-4];
  wire                          wide_s = s2_ff[SW-5];
  wire                          ser_s  = s2_ff[SW-6];
  wire [hbl_pkg::ADDR_W-1:0]    addr_s =
    s2_ff[hbl_pkg::DATA_W +: hbl_pkg::ADDR_W];
  wire [hbl_pkg::DATA_W-1:0]    d_s    = s2_ff[hbl_pkg::DATA_W-1:0];
  wire [hbl_pkg::BYTE_W-1:0]    d_lo   = d_s[7:0];
  wire [hbl_pkg::BYTE_W-1:0]    d_hi   = d_s[15:8];
  // ---------------------------------------------------------------
  // address latch
  // ---------------------------------------------------------------
  logic [hbl_pkg::ADDR_W-1:0]   alat_ff;     // held address
  logic [hbl_pkg::ADDR_W-1:0]   nxt_alat;
  // transparent while the strobe is high, frozen while it is low
  assign nxt_alat = ale_s ? addr_s : alat_ff;
  // a host without address multiplexing keeps ale high, so the
  // latch simply follows the pins
  wire [hbl_pkg::ADDR_W-1:0]    addr_eff = nxt_alat;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alat_ff <= {hbl_pkg::ADDR_W{1'b0}};
    end else begin
      alat_ff <= nxt_alat;
    end
  end
  // ---------------------------------------------------------------
  // register selection
  // ---------------------------------------------------------------
  logic [hbl_pkg::IDX_W-1:0]    idx_ff;      // register index
  logic                         a0_ff;       // byte pick or lane swap
  logic                         wide_ff;     // registered width
  // bits 8:1 name the word; bit 0 is byte address or swap strap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_ff  <= hbl_pkg::ZERO8;
      a0_ff   <= 1'b0;
      wide_ff <= 1'b0;
    end else begin
      idx_ff  <= addr_eff[hbl_pkg::IDX_LSB +: hbl_pkg::IDX_W];
      a0_ff   <= addr_eff[0];
      wide_ff <= wide_s;
    end
  end
  assign reg_index   = idx_ff;
  // narrow width: a0 is the true byte address; wide: it is a strap
  // that only the host can keep steady
  assign reg_byte_hi = a0_ff & ~wide_ff;
  // ---------------------------------------------------------------
  // read lane steering
  // ---------------------------------------------------------------
  wire [hbl_pkg::BYTE_W-1:0]    r_lo = reg_rdata[7:0];
  wire [hbl_pkg::BYTE_W-1:0]    r_hi = reg_rdata[15:8];
  wire [hbl_pkg::BYTE_W-1:0]    lane_lo = a0_ff ? r_hi : r_lo;
  wire [hbl_pkg::BYTE_W-1:0]    lane_hi = (wide_ff && !a0_ff) ? r_hi :
                                          wide_ff ? r_lo : hbl_pkg::ZERO8;
  // wide with swap set: the lanes cross; clear: natural order
  wire [hbl_pkg::DATA_W-1:0]    rd_word = {lane_hi, lane_lo};
  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  logic [hbl_pkg::DATA_W-1:0]   dout_ff;     // data pin values
  logic [hbl_pkg::DATA_W-1:0]   doe_ff;      // data pin enables
  logic [hbl_pkg::DATA_W-1:0]   nxt_dout;
  logic [hbl_pkg::DATA_W-1:0]   nxt_doe;
  wire                          par_rd = cs_s & rd_s & ~ser_s;
  wire [hbl_pkg::DATA_W-1:0]    ser_bit =
    {{(hbl_pkg::DATA_W-1){1'b0}}, 1'b1} << hbl_pkg::SER_OUT_BIT;
  // enable choice: serial drives only bit 0, narrow only the low
  // byte, wide both bytes; nothing while deselected
  always_comb begin
    nxt_doe  = hbl_pkg::ZERO16;
    nxt_dout = hbl_pkg::ZERO16;
    if (ser_s) begin
      // bit 1 stays an input in serial mode
      nxt_doe  = cs_s ? ser_bit : hbl_pkg::ZERO16;
      nxt_dout = ser_sdo ? ser_bit : hbl_pkg::ZERO16;
    end else if (par_rd) begin
      // upper byte never driven in narrow width
      nxt_doe  = {(wide_s ? hbl_pkg::ONES8 : hbl_pkg::ZERO8),
                  hbl_pkg::ONES8};
      nxt_dout = rd_word;
    end else begin
      nxt_doe  = hbl_pkg::ZERO16;
      nxt_dout = hbl_pkg::ZERO16;
    end
  end
  // async reset drops every enable at once, before any clock edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_ff <= hbl_pkg::ZERO16;
      doe_ff  <= hbl_pkg::ZERO16;
    end else begin
      dout_ff <= nxt_dout;
      doe_ff  <= nxt_doe;
    end
  end
  assign pins.d_d_o  = dout_ff;
  assign pins.d_d_oe = doe_ff;
  // ---------------------------------------------------------------
  // write capture
  // ---------------------------------------------------------------
  logic                         wr_prev_ff;  // strobe one cycle ago
  logic                         cs_prev_ff;  // select one cycle ago
  logic                         rd_prev_ff;  // read one cycle ago
  logic                         wr_ff;       // write pulse
  logic                         rd_ff;       // read start pulse
  logic [hbl_pkg::DATA_W-1:0]   wdat_ff;
  logic [1:0]                   wbe_ff;
  // the write is taken when the strobe rises inside a selected
  // access; select must still have been low then
  wire wr_end   = wr_prev_ff & ~wr_s & cs_prev_ff & ~ser_s;
  wire rd_start = par_rd & ~rd_prev_ff;
  wire [hbl_pkg::DATA_W-1:0]    w_word =
    !wide_s ? {d_lo, d_lo} :
    a0_ff   ? {d_lo, d_hi} : {d_hi, d_lo};
  wire [1:0] w_be = !wide_s ? (a0_ff ? 2'h2 : 2'h1) : 2'h3;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b0;
      rd_prev_ff <= 1'b0;
      wr_ff      <= 1'b0;
      rd_ff      <= 1'b0;
      wdat_ff    <= hbl_pkg::ZERO16;
      wbe_ff     <= 2'h0;
    end else begin
      wr_prev_ff <= wr_s;
      cs_prev_ff <= cs_s;
      rd_prev_ff <= par_rd;
      wr_ff      <= wr_end;
      rd_ff      <= rd_start;
      if (wr_end) begin
        wdat_ff <= w_word;
        wbe_ff  <= w_be;
      end
    end
  end
  assign reg_wr    = wr_ff;
  assign reg_rd    = rd_ff;
  assign reg_wdata = wdat_ff;
  assign reg_wbe   = wbe_ff;
  // ---------------------------------------------------------------
  // serial side
  // ---------------------------------------------------------------
  // host-to-device serial bit, already through the synchroniser
  assign ser_sdi = d_s[hbl_pkg::SER_IN_BIT];
  assign ser_cs  = cs_s & ser_s;
endmodule

// File: tb/hbl_chk.sv
// assertions on the pin bundle between the host end and the device end
`timescale 1ns/1ps
module hbl_chk (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       arst_n,
  // host driven pins
  input wire logic                       cs_n,
  input wire logic                       rd_n,
  input wire logic                       wr_n,
  input wire logic                       wide,
  input wire logic                       serial,
  // data pin enables of both ends
  input wire logic [hbl_pkg::DATA_W-1:0] h_d_oe,
  input wire logic [hbl_pkg::DATA_W-1:0] d_d_oe
);
  // ------------------------------------------------------------------
  // one clock domain, so clock and reset are given once
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // select high past the sync lag leaves every pin undriven by the device
  float_sel_a: assert property (
    cs_n [*5] |-> d_d_oe == hbl_pkg::ZERO16)
    else $error("data pins driven while deselected");
  // serial input pin belongs to the host alone
  ser_in_a: assert property (
    serial |-> !d_d_oe[1])
    else $error("device drives serial input pin");
  // a settled serial select drives bit 0 and nothing else
  ser_out_a: assert property (
    (serial && !cs_n) [*5] |-> d_d_oe == 16'h0001)
    else $error("serial output lane wrong");
  // narrow width never touches the upper lane
  narrow_hi_a: assert property (
    !wide [*4] |-> d_d_oe[15:8] == hbl_pkg::ZERO8)
    else $error("upper lane driven in narrow width");
  // narrow read drives the whole low lane
  narrow_lo_a: assert property (
    (!wide && !serial && d_d_oe != hbl_pkg::ZERO16)
    |-> d_d_oe[7:0] == hbl_pkg::ONES8)
    else $error("low lane partly driven");
  // wide read drives both lanes together
  wide_both_a: assert property (
    (wide && !serial && d_d_oe != hbl_pkg::ZERO16)
    |-> d_d_oe == ~hbl_pkg::ZERO16)
    else $error("wide read lanes incomplete");
  // the two ends never fight over a pin
  no_fight_a: assert property (
    (h_d_oe & d_d_oe) == hbl_pkg::ZERO16)
    else $error("both ends drive one data pin");
  // select covers strobes and the write hold cycle
  cs_hold_a: assert property (
    (!rd_n || !wr_n || $rose(wr_n)) |-> !cs_n)
    else $error("strobe outside device select");
endmodule

// File: tb/hbl_test.sv
// self-checking bench joining the host end and the device end
`timescale 1ns/1ps
module hbl_test;
  // ------------------------------------------------------------------
  // stimulus, observed values and counters
  // ------------------------------------------------------------------
  logic        clk = 1'h0, arst_n = 1'h0;        // clock, reset low active
  logic        c_wide = 1'h1, c_swap = 1'h0;     // width and lane exchange
  logic        c_ser = 1'h0, c_mux = 1'h0;       // serial and muxed modes
  logic        cmd_valid = 1'h0, cmd_write = 1'h0, cmd_ready, rsp_valid;
  logic [7:0]  cmd_index = 8'h00, reg_index, acc_idx;
  logic [15:0] cmd_wdata = 16'h0000, rsp_rdata, reg_wdata, w_data, last_d;
  logic [15:0] reg_rdata;                        // register word per index
  logic [1:0]  reg_wbe, w_be;
  logic        w_hi;                             // byte pick of last write
  logic        h_ser_cs = 1'h0, ser_mosi = 1'h0, ser_sdo = 1'h0;
  logic        ser_miso, ser_sdi, d_ser_cs, reg_byte_hi, reg_rd, reg_wr;
  int          n_errors = 0, check_count = 0, w_cnt = 0;
  always #5 clk = ~clk;
  // word depends on the index so a wrong decode shows up
  assign reg_rdata = {~reg_index, reg_index};
  hbl_if hbl_if_inst ();
  hbl_host hbl_host_inst (.clk(clk), .arst_n(arst_n), .pins(hbl_if_inst),
    .cfg_wide(c_wide), .cfg_swap(c_swap), .cfg_serial(c_ser),
    .cfg_muxed(c_mux), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ser_cs(h_ser_cs),
    .ser_mosi(ser_mosi), .ser_miso(ser_miso));
  hbl_dev hbl_dev_inst (.clk(clk), .arst_n(arst_n), .pins(hbl_if_inst),
    .reg_index(reg_index), .reg_byte_hi(reg_byte_hi), .reg_rdata(reg_rdata),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_wbe(reg_wbe), .ser_sdi(ser_sdi), .ser_sdo(ser_sdo),
    .ser_cs(d_ser_cs));
  hbl_chk hbl_chk_inst (.clk(clk), .arst_n(arst_n), .cs_n(hbl_if_inst.cs_n),
    .rd_n(hbl_if_inst.rd_n), .wr_n(hbl_if_inst.wr_n),
    .wide(hbl_if_inst.wide), .serial(hbl_if_inst.serial),
    .h_d_oe(hbl_if_inst.h_d_oe), .d_d_oe(hbl_if_inst.d_d_oe));
  // last driven pin word, decoded index and last write seen
  always @(posedge clk) begin
    if (hbl_if_inst.d_d_oe != 16'h0000)
      last_d <= hbl_if_inst.d;
    if (reg_rd === 1'h1 || reg_wr === 1'h1)
      acc_idx <= reg_index;
    if (reg_wr === 1'h1) begin
      w_data <= reg_wdata;
      w_be <= reg_wbe;
      w_hi <= reg_byte_hi;
      w_cnt <= w_cnt + 1;
    end
  end
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one command, waiting boundedly for the answer pulse
  task automatic acc(input logic wr, input logic [7:0] idx,
                     input logic [15:0] wd);
    int n;
    cmd_write = wr;
    cmd_index = idx;
    cmd_wdata = wd;
    cmd_valid = 1'h1;
    @(posedge clk);
    #1 cmd_valid = 1'h0;
    n = 0;
    while (rsp_valid !== 1'h1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 100)
      n_errors++;
  endtask
  // config changes only while idle, then one edge to settle
  task automatic set_cfg(input logic wd, sw, mx);
    c_wide = wd;
    c_swap = sw;
    c_mux = mx;
    @(posedge clk);
    #1;
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_read(input logic wd, sw, mx, input logic [7:0] idx);
    logic [15:0] w;
    w = {~idx, idx};
    set_cfg(wd, sw, mx);
    acc(1'h0, idx, 16'h0000);
    chk(rsp_rdata, w);
    chk({8'h00, acc_idx}, {8'h00, idx});
    if (!wd)
      chk(last_d, {8'hFF, w[15:8]});
    else
      chk(last_d, sw ? {w[7:0], w[15:8]} : w);
    $display("read test done, index %h", idx);
  endtask
  task automatic t_write(input logic wd, sw, input logic [15:0] v);
    int w0;
    set_cfg(wd, sw, 1'h1);
    w0 = w_cnt;
    acc(1'h1, 8'hC3, v);
    // the device registers the write one cycle after the answer
    repeat (3) @(posedge clk);
    #1 chk({8'h00, acc_idx}, 16'h00C3);
    chk(16'(w_cnt - w0), wd ? 16'h0001 : 16'h0002);
    chk({14'h0000, w_be}, wd ? 16'h0003 : 16'h0002);
    chk({15'h0000, w_hi}, {15'h0000, !wd});
    chk(w_data, wd ? v : {2{v[15:8]}});
    $display("write test done, data %h", v);
  endtask
  // serial passthrough both ways, then a reset while driving
  task automatic t_serial;
    c_ser = 1'h1;
    for (int k = 0; k < 2; k++) begin
      h_ser_cs = 1'h1;
      ser_mosi = k[0];
      ser_sdo = ~k[0];
      repeat (12) @(posedge clk);
      #1 chk({15'h0000, ser_sdi}, {15'h0000, k[0]});
      chk({15'h0000, ser_miso}, {15'h0000, ~k[0]});
      chk({15'h0000, hbl_if_inst.d[0]}, {15'h0000, ~k[0]});
      chk({15'h0000, d_ser_cs}, 16'h0001);
    end
    @(posedge clk);
    #1 arst_n = 1'h0;
    #1 chk(hbl_if_inst.d_d_oe, 16'h0000);
    h_ser_cs = 1'h0;
    c_ser = 1'h0;
    repeat (3) @(posedge clk);
    #1 arst_n = 1'h1;
    $display("serial test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 chk(hbl_if_inst.d_d_oe, 16'h0000);
    arst_n = 1'h1;
    t_read(1'h1, 1'h0, 1'h0, 8'h5A);
    t_read(1'h1, 1'h1, 1'h0, 8'hA5);
    t_read(1'h0, 1'h0, 1'h0, 8'h3C);
    t_read(1'h1, 1'h0, 1'h1, 8'h96);
    t_read(1'h0, 1'h0, 1'h1, 8'h01);
    t_write(1'h1, 1'h0, 16'h1234);
    t_write(1'h1, 1'h1, 16'hBEEF);
    t_write(1'h0, 1'h0, 16'hCAFE);
    t_serial;
    t_read(1'h1, 1'h1, 1'h0, 8'hFF);
    end_sim;
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #30000;
    n_errors++;
    end_sim;
  end
endmodule
